// ### logic/result_status_map.svh
// Field positions, fixed values and counts of the result status bytes
`ifndef RESULT_STATUS_MAP_SVH
`define RESULT_STATUS_MAP_SVH
`define RS_CC_NORMAL       2'h0
`define RS_CC_ABNORMAL     2'h1
`define RS_CC_INVALID      2'h2
`define RS_CC_POLLING      2'h3
`define RS_RECAL_STEPS     7'h50
`define RS_BAD_TRACK_ID    8'hFF
`define RS_RATE_500K       2'h0
`define RS_RATE_300K       2'h1
`define RS_RATE_250K       2'h2
`define RS_RATE_1M         2'h3
`define RS_MODE_BIT_POS    6
`define RS_ENC_BIT_POS     5
`define RS_CFG3_RESET      8'h00
`define RS_BYTE_COUNT      3'h4
`define RS_DENSITY_RESET   1'h1
`endif

// ### logic/result_status_pkg.sv
// Types shared by the result status logic
package result_status_pkg;
    typedef struct packed {
        logic [1:0] completionCode;
        logic       positioningDone;
        logic       relSeekPastZero;
        logic       pastLastSector;
        logic       idCrcFault;
        logic       payloadCrcFault;
        logic       serviceLate;
        logic       sectorMissing;
        logic       readIdFail;
        logic       trackSeqFail;
        logic       idSyncAbsent;
        logic       dataSyncAbsent;
        logic       deletedMismatch;
        logic       isWriteCmd;
    } exec_events_t;

    typedef struct packed {
        logic [7:0] completionStatus;
        logic [7:0] transferFaultStatus;
        logic [7:0] mediaFaultStatus;
        logic [7:0] driveSignalStatus;
    } status_bytes_t;

    typedef enum logic [1:0] {
        IDLE,
        EXEC,
        RESULT
    } phase_t;
endpackage : result_status_pkg

// ### logic/density_encoder.sv
// Density select output encoding from data rate and register mode
`timescale 1ns/1ps
`include "result_status_map.svh"
module density_encoder (
    // Clocking
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       ce,
    // Controls
    input  wire logic [1:0] dataRate,
    input  wire logic       modeBit,
    // Pin
    output logic            densityOutput
);
    typedef struct packed {
        logic densityOutput_r;
    } dens_state_t;

    dens_state_t st_r;
    dens_state_t st_nxt;
    logic        fastRate;

    // High density rates are 1M and 500k
    always_comb begin
        fastRate = (dataRate == `RS_RATE_1M) || (dataRate == `RS_RATE_500K);
        st_nxt = st_r;
        st_nxt.densityOutput_r = modeBit ? fastRate : !fastRate; // [RULE_01]
    end

    // Pin is high after hardware reset
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_r <= '{densityOutput_r: `RS_DENSITY_RESET};
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign densityOutput = st_r.densityOutput_r;

    density_map_a: assert property (@(posedge mclk) disable iff (rst) // [RULE_01]
        ce |=> densityOutput == ($past(modeBit) ==
            ($past(dataRate) == `RS_RATE_1M || $past(dataRate) == `RS_RATE_500K)))
        else $error("density output wrong for rate and mode");
endmodule : density_encoder

// ### logic/floppy_result_status.sv
// Result phase status bytes of the floppy controller and density output
//
// Summary of operation
// [RULE_01] Density output high at fast rates when mode bit is 1, else reversed.
// [RULE_02] After a command with results, status bytes are read through data port.
// [RULE_03] Byte 0 bits 7:6 hold the completion code.
// [RULE_04] Byte 0 bit 5 set when seek, relative seek or recalibrate ends.
// [RULE_05] Byte 0 bit 4 set on recalibrate timeout or stepping past zero.
// [RULE_06] Byte 0 bit 3 zero, bit 2 head, bits 1:0 drive number.
// [RULE_07] Byte 1 bit 7 set past last sector; bit 6 zero.
// [RULE_08] Byte 1 bit 5 set on ID or data field CRC failure.
// [RULE_09] Byte 1 bit 4 set on overrun or underrun; bit 3 zero.
// [RULE_10] Byte 1 bit 2 set when sector, ID or sequence not found.
// [RULE_11] Byte 1 bit 1 set if write protect rises during a write command.
// [RULE_12] Byte 1 bit 0 set when ID or data address mark missing.
// [RULE_13] Byte 2 bit 6 set on deleted mark mismatch; bit 7 zero.
// [RULE_14] Byte 2 bit 5 set on data field CRC failure.
// [RULE_15] Byte 2 bit 4 set on track mismatch; bits 3:2 zero.
// [RULE_16] Byte 2 bit 1 set on track mismatch with ID track FF.
// [RULE_17] Byte 2 bit 0 set when no data or deleted mark found.
// [RULE_18] Byte 3 bit 7 zero, bits 5 and 3 one, bit 4 track zero.
// [RULE_19] Byte 3 bit 6 write protect, bit 2 head, bits 1:0 drive select.
// [RULE_20] Mode bit is config register 3 bit 6, encoding bit is bit 5.
// [RULE_21] Flags captured at end of execution, held until all bytes read.
`timescale 1ns/1ps
`include "result_status_map.svh"
module floppy_result_status
    import result_status_pkg::*;
(
    // Clocking
    input  wire logic                            mclk,
    input  wire logic                            rst,
    input  wire logic                            ce,
    // Command engine
    input  wire logic                            execStart,
    input  wire logic                            execDone,
    input  wire logic                            hasResult,
    input  wire logic                            senseCmd,
    input  wire logic                            recalStep,
    input  wire logic                            recalCmd,
    input  wire logic                            idValid,
    input  wire logic [7:0]                      idTrack,
    input  wire logic [7:0]                      curTrack,
    input  wire result_status_pkg::exec_events_t execEvents,
    input  wire logic [1:0]                      dataRate,
    input  wire logic                            cfg3Write,
    input  wire logic [7:0]                      cfg3Data,
    // Drive outputs as driven by the controller
    input  wire logic                            side_select_pin,
    input  wire logic [1:0]                      unit_select_bits,
    // Drive cable pins
    input  wire logic                            home_track_input,
    input  wire logic                            writeProtectIn,
    // Data port, result side
    input  wire logic                            resultRead,
    output logic                                 resultValid,
    output logic [7:0]                           resultData,
    output logic                                 resultLast,
    // Status views
    output result_status_pkg::status_bytes_t     statusBytes,
    output logic                                 modeBit,
    output logic                                 encoding_mode_bit,
    output logic                                 density_output
);
    typedef struct packed {
        phase_t        phase;
        logic [1:0]    homeSync1;
        logic [1:0]    homeSync2;
        logic [1:0]    wpSync1;
        logic [1:0]    wpSync2;
        logic [6:0]    stepCount;
        logic          trackMismatch;
        logic          badTrack;
        logic          writeLocked;
        logic          seekDone;
        logic [7:0]    cfg3;
        status_bytes_t held;
        logic [2:0]    readIdx;
        logic [7:0]    dataOut;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic          homeTrack;
    logic          writeProt;
    logic          wpRise;
    logic          trackZeroFault;
    status_bytes_t live;
    logic [7:0]    sel;

    // Synchronised pin levels, second stage only
    assign homeTrack = st_r.homeSync2[0];
    assign writeProt = st_r.wpSync2[0];
    assign wpRise    = st_r.wpSync2[0] && !st_r.wpSync2[1];

    // Recalibrate timeout or stepping past zero
    assign trackZeroFault = (recalCmd && !homeTrack
                             && st_r.stepCount >= `RS_RECAL_STEPS) // [RULE_05]
                            || execEvents.relSeekPastZero;         // [RULE_05]

    // Live status words from current events and pins
    always_comb begin
        live.completionStatus = {execEvents.completionCode,     // [RULE_03]
                                 st_r.seekDone,                 // [RULE_04]
                                 trackZeroFault,                // [RULE_05]
                                 1'h0,                          // [RULE_06]
                                 side_select_pin,               // [RULE_06]
                                 unit_select_bits};             // [RULE_06]
        live.transferFaultStatus = {execEvents.pastLastSector,  // [RULE_07]
                                    1'h0,                       // [RULE_07]
                                    execEvents.idCrcFault
                                    || execEvents.payloadCrcFault, // [RULE_08]
                                    execEvents.serviceLate,     // [RULE_09]
                                    1'h0,                       // [RULE_09]
                                    execEvents.sectorMissing
                                    || execEvents.readIdFail
                                    || execEvents.trackSeqFail, // [RULE_10]
                                    st_r.writeLocked,           // [RULE_11]
                                    execEvents.idSyncAbsent
                                    || execEvents.dataSyncAbsent}; // [RULE_12]
        live.mediaFaultStatus = {1'h0,                          // [RULE_13]
                                 execEvents.deletedMismatch,    // [RULE_13]
                                 execEvents.payloadCrcFault,    // [RULE_14]
                                 st_r.trackMismatch,            // [RULE_15]
                                 2'h0,                          // [RULE_15]
                                 st_r.badTrack,                 // [RULE_16]
                                 execEvents.dataSyncAbsent};    // [RULE_17]
        live.driveSignalStatus = {1'h0,                         // [RULE_18]
                                  writeProt,                    // [RULE_19]
                                  1'h1,                         // [RULE_18]
                                  homeTrack,                    // [RULE_18]
                                  1'h1,                         // [RULE_18]
                                  side_select_pin,              // [RULE_19]
                                  unit_select_bits};            // [RULE_19]
    end

    // Result byte selected by read index, byte 0 first
    always_comb begin
        case (st_r.readIdx)
            3'h0: sel = st_r.held.completionStatus;
            3'h1: sel = st_r.held.transferFaultStatus;
            3'h2: sel = st_r.held.mediaFaultStatus;
            3'h3: sel = st_r.held.driveSignalStatus;
            default: sel = 8'h00;
        endcase
    end

    // Next state: sync, event tracking, phase sequencing
    always_comb begin
        st_nxt = st_r;
        st_nxt.homeSync1 = {st_r.homeSync1[0], home_track_input};
        st_nxt.homeSync2 = {st_r.homeSync2[0], st_r.homeSync1[1]};
        st_nxt.wpSync1   = {st_r.wpSync1[0], writeProtectIn};
        st_nxt.wpSync2   = {st_r.wpSync2[0], st_r.wpSync1[1]};
        if (cfg3Write) begin
            st_nxt.cfg3 = cfg3Data; // [RULE_20]
        end
        // Seek end flag reported once by the sense command
        if (st_r.phase == RESULT && senseCmd && resultRead && resultLast) begin
            st_nxt.seekDone = 1'h0;
        end
        if (execDone && execEvents.completionCode != `RS_CC_INVALID
            && (recalCmd || execEvents.relSeekPastZero || senseCmd == 1'h0
                && !hasResult)) begin
            st_nxt.seekDone = 1'h1; // [RULE_04]
        end
        case (st_r.phase)
            IDLE: begin
                if (execStart) begin
                    st_nxt.phase         = EXEC;
                    st_nxt.stepCount     = 7'h00;
                    st_nxt.trackMismatch = 1'h0;
                    st_nxt.badTrack      = 1'h0;
                    st_nxt.writeLocked   = 1'h0;
                end
            end
            EXEC: begin
                if (recalStep && st_r.stepCount != 7'h7F) begin
                    st_nxt.stepCount = st_r.stepCount + 7'h01;
                end
                if (idValid && idTrack != curTrack) begin
                    st_nxt.trackMismatch = 1'h1; // [RULE_15]
                    if (idTrack == `RS_BAD_TRACK_ID) begin
                        st_nxt.badTrack = 1'h1; // [RULE_16]
                    end
                end
                if (execEvents.isWriteCmd && wpRise) begin
                    st_nxt.writeLocked = 1'h1; // [RULE_11]
                end
                if (execDone) begin
                    st_nxt.held    = live; // [RULE_21]
                    st_nxt.readIdx = 3'h0;
                    st_nxt.dataOut = live.completionStatus;
                    st_nxt.phase   = hasResult ? RESULT : IDLE; // [RULE_02]
                end
            end
            RESULT: begin
                if (resultRead) begin
                    if (resultLast) begin
                        st_nxt.phase = IDLE; // [RULE_21]
                    end else begin
                        st_nxt.readIdx = st_r.readIdx + 3'h1;
                    end
                end
            end
            default: st_nxt.phase = IDLE;
        endcase
        // Keep data register aligned with the byte now offered
        if (st_r.phase == RESULT && resultRead && !resultLast) begin
            case (st_r.readIdx)
                3'h0: st_nxt.dataOut = st_r.held.transferFaultStatus;
                3'h1: st_nxt.dataOut = st_r.held.mediaFaultStatus;
                default: st_nxt.dataOut = st_r.held.driveSignalStatus;
            endcase
        end
    end

    // State register; ce freezes everything
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_r <= '{phase: IDLE, cfg3: `RS_CFG3_RESET, default: '0};
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // Data port result side
    assign resultValid = (st_r.phase == RESULT);                   // [RULE_02]
    assign resultData  = st_r.dataOut;                             // [RULE_02]
    assign resultLast  = (st_r.readIdx == (`RS_BYTE_COUNT - 3'h1));
    assign statusBytes = st_r.held;
    assign modeBit           = st_r.cfg3[`RS_MODE_BIT_POS];        // [RULE_20]
    assign encoding_mode_bit = st_r.cfg3[`RS_ENC_BIT_POS];         // [RULE_20]

    // Density output pin encoding
    density_encoder u_density (
        .mclk          (mclk),
        .rst           (rst),
        .ce            (ce),
        .dataRate      (dataRate),
        .modeBit       (modeBit),
        .densityOutput (density_output)
    );

    held_stable_a: assert property (@(posedge mclk) disable iff (rst) // [RULE_21]
        (st_r.phase == RESULT && !(ce && resultRead && resultLast))
        |=> $stable(st_r.held))
        else $error("status bytes changed during result phase");
    byte0_zero_a: assert property (@(posedge mclk) disable iff (rst) // [RULE_06]
        resultValid |-> statusBytes.completionStatus[3] == 1'h0)
        else $error("byte 0 bit 3 not zero");
    byte3_fixed_a: assert property (@(posedge mclk) disable iff (rst) // [RULE_18]
        resultValid |-> statusBytes.driveSignalStatus[7] == 1'h0
            && statusBytes.driveSignalStatus[5] == 1'h1
            && statusBytes.driveSignalStatus[3] == 1'h1)
        else $error("byte 3 fixed bits wrong");
    byte1_zero_a: assert property (@(posedge mclk) disable iff (rst) // [RULE_09]
        resultValid |-> statusBytes.transferFaultStatus[6] == 1'h0
            && statusBytes.transferFaultStatus[3] == 1'h0)
        else $error("byte 1 unused bits set");
    byte2_zero_a: assert property (@(posedge mclk) disable iff (rst) // [RULE_15]
        resultValid |-> statusBytes.mediaFaultStatus[7] == 1'h0
            && statusBytes.mediaFaultStatus[3:2] == 2'h0)
        else $error("byte 2 unused bits set");
    bad_track_a: assert property (@(posedge mclk) disable iff (rst) // [RULE_16]
        ce && st_r.phase == EXEC && idValid && idTrack != curTrack
        && idTrack == `RS_BAD_TRACK_ID |=> st_r.badTrack)
        else $error("bad track flag not set");
    first_byte_a: assert property (@(posedge mclk) disable iff (rst) // [RULE_03]
        ce && st_r.phase == EXEC && execDone && hasResult
        |=> resultValid && resultData[7:6] == $past(execEvents.completionCode))
        else $error("first result byte lacks completion code");
    read_order_a: assert property (@(posedge mclk) disable iff (rst) // [RULE_02]
        ce && resultValid && resultRead && st_r.readIdx == 3'h2
        |=> resultData == statusBytes.driveSignalStatus)
        else $error("fourth result byte is not byte 3");
endmodule : floppy_result_status

// ### tb/host_reader.sv
// Host model that drains the result bytes from the data port
`timescale 1ns/1ps
module host_reader (
    // Clock and bench control
    input  wire logic        mclk,
    input  wire logic        arm,
    input  wire logic        slow,
    // Data port, result side
    input  wire logic        resultValid,
    input  wire logic [7:0]  resultData,
    input  wire logic        resultLast,
    output logic             resultRead,
    // Bytes taken so far
    output logic [31:0]      got,
    output logic             done,
    output logic             lastOk
);
    logic [2:0] cnt = 3'h0;
    logic       gap = 1'b0;

    initial {resultRead, got, lastOk} = {1'b0, 32'h0, 1'b1};
    assign done = (cnt == 3'h4);

    // Read pulse moves at the falling edge, so it is steady when sampled
    always @(negedge mclk) begin
        gap <= ~gap;
        resultRead <= arm && resultValid === 1'b1 && !done
                      && (!slow || gap);
    end

    // Byte taken at the edge that samples the read pulse
    always @(posedge mclk) begin
        if (!arm) begin
            cnt <= 3'h0;
            lastOk <= 1'b1;
        end else if (resultRead && resultValid) begin
            got <= {got[23:0], resultData};
            cnt <= cnt + 3'h1;
            if (resultLast !== (cnt == 3'h3)) lastOk <= 1'b0;
        end
    end
endmodule : host_reader

// ### tb/tb.sv
// Self-checking bench for the result status bytes and density pin
`timescale 1ns/1ps
`include "result_status_map.svh"
`define CHECK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module tb;
    import result_status_pkg::*;
    // Design pins
    logic         mclk, rst, ce, execStart, execDone, hasResult, senseCmd;
    logic         recalStep, recalCmd, idValid, cfg3Write, side_select_pin;
    logic         home_track_input, writeProtectIn, resultRead, resultValid;
    logic         resultLast, modeBit, encoding_mode_bit, density_output;
    logic [1:0]   dataRate, unit_select_bits;
    logic [7:0]   idTrack, curTrack, cfg3Data, resultData, idt;
    exec_events_t execEvents;
    status_bytes_t sb;
    // Host model and bench state
    logic         arm, slow, hostDone, hostOk, wr;
    logic [31:0]  hostGot;
    int           miscompares, checked;

    floppy_result_status uut (
        .mclk, .rst, .ce, .execStart, .execDone, .hasResult, .senseCmd,
        .recalStep, .recalCmd, .idValid, .idTrack, .curTrack, .execEvents,
        .dataRate, .cfg3Write, .cfg3Data, .side_select_pin,
        .unit_select_bits, .home_track_input, .writeProtectIn, .resultRead,
        .resultValid, .resultData, .resultLast, .statusBytes(sb),
        .modeBit, .encoding_mode_bit, .density_output
    );
    host_reader host (
        .mclk, .arm, .slow, .resultValid, .resultData, .resultLast,
        .resultRead, .got(hostGot), .done(hostDone), .lastOk(hostOk)
    );

    // 200 MHz clock
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic test_done;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done

    // One command through execution, then drained and compared whole
    task automatic run_cmd(input exec_events_t ev, input logic [3:0] fl,
                           input int steps, input logic [15:0] mid);
        logic [31:0] exp;
        int          n;
        @(negedge mclk);
        {execEvents, recalCmd, senseCmd, execStart} = {ev, fl[3:2], 1'b1};
        @(negedge mclk);
        execStart = 1'b0;
        repeat (steps) begin
            recalStep = 1'b1;
            @(negedge mclk);
            recalStep = 1'b0;
            @(negedge mclk);
        end
        {idTrack, idValid} = {idt, 1'b1};
        @(negedge mclk);
        {idValid, writeProtectIn} = {1'b0, wr};
        // Cable pins lag by their synchroniser
        repeat (5) @(negedge mclk);
        exp = {ev.completionCode, fl[1:0], 1'b0, side_select_pin,
               unit_select_bits, mid, 1'b0, wr, 1'b1, home_track_input,
               1'b1, side_select_pin, unit_select_bits};
        execDone = 1'b1;
        @(negedge mclk);
        execDone = 1'b0;
        `CHECK(resultValid, 1'b1)
        `CHECK(sb, exp)
        // Pins move in the result phase; held bytes must not follow
        {side_select_pin, unit_select_bits, home_track_input} ^= 4'hF;
        {slow, arm} = {~slow, 1'b1};
        for (n = 0; n < 40 && !hostDone; n++) @(negedge mclk);
        if (!hostDone) begin
            miscompares++;
            test_done();
        end
        `CHECK(resultValid, 1'b0)
        `CHECK(hostGot, exp)
        `CHECK(hostOk, 1'b1)
        {side_select_pin, unit_select_bits, home_track_input} ^= 4'hF;
        {arm, recalCmd, senseCmd, writeProtectIn, wr} = '0;
        idt = 8'h05;
        @(negedge mclk);
    endtask : run_cmd

    // Every rate under both polarities of the mode bit
    task automatic t_density;
        logic fast;
        for (int m = 0; m < 2; m++) begin
            {cfg3Data, cfg3Write} = {m[0] ? 8'h60 : 8'h20, 1'b1};
            @(negedge mclk);
            cfg3Write = 1'b0;
            for (int r = 0; r < 4; r++) begin
                dataRate = 2'(r);
                fast = dataRate == `RS_RATE_1M || dataRate == `RS_RATE_500K;
                repeat (3) @(negedge mclk);
                `CHECK(density_output, m[0] ? fast : !fast)
            end
            `CHECK({modeBit, encoding_mode_bit}, {m[0], 1'b1})
        end
        $display("density test done");
    endtask : t_density

    // All completion codes with varied head, unit and track zero
    task automatic t_codes;
        for (int c = 0; c < 4; c++) begin
            {side_select_pin, unit_select_bits} = {c[0], 2'(3 - c)};
            home_track_input = c[1];
            run_cmd(exec_events_t'(15'(c) << 13), 4'h0, 0, 16'h0);
        end
        $display("codes test done");
    endtask : t_codes

    // Each fault event alone, write protect, track compare
    task automatic t_faults;
        logic [15:0] fe [1:10] = '{16'h0040, 16'h0101, 16'h0100, 16'h0400,
            16'h0400, 16'h0400, 16'h1000, 16'h2020, 16'h2000, 16'h8000};
        exec_events_t b;
        b = exec_events_t'(15'h2000);
        for (int k = 1; k <= 5; k++) begin
            run_cmd(b | (15'h1 << k), 4'h0, 0, fe[k]);
        end
        for (int k = 6; k <= 10; k++) begin
            run_cmd(b | (15'h1 << k), 4'h0, 0, fe[k]);
        end
        wr = 1'b1;
        run_cmd(b | 15'h1, 4'h0, 0, 16'h0200);
        wr = 1'b1;
        run_cmd(b, 4'h0, 0, 16'h0000);
        idt = 8'h07;
        run_cmd(b, 4'h0, 0, 16'h0010);
        idt = 8'hFF;
        run_cmd(b, 4'h0, 0, 16'h0012);
        $display("faults test done");
    endtask : t_faults

    // Recalibrate either side of the step limit, seek end until sensed
    task automatic t_seek;
        home_track_input = 1'b0;
        // Seek end shows in the following sense result, not its own
        run_cmd('0, 4'h8, 79, 16'h0);
        run_cmd('0, 4'h6, 0, 16'h0);
        run_cmd('0, 4'h9, 80, 16'h0);
        run_cmd('0, 4'h6, 0, 16'h0);
        run_cmd(exec_events_t'(15'h0800), 4'h1, 0, 16'h0);
        run_cmd('0, 4'h6, 0, 16'h0);
        run_cmd('0, 4'h0, 0, 16'h0);
        $display("seek test done");
    endtask : t_seek

    // Reset, then the scenarios in turn
    initial begin
        {execStart, execDone, senseCmd, recalStep, recalCmd, idValid,
         cfg3Write, side_select_pin, home_track_input, writeProtectIn,
         arm, slow, wr} = '0;
        {unit_select_bits, dataRate, idTrack, cfg3Data, execEvents} = '0;
        {ce, hasResult, curTrack, idt} = {2'h3, 8'h05, 8'h05};
        {miscompares, checked, rst} = {32'h0, 32'h0, 1'b1};
        repeat (12) @(negedge mclk);
        `CHECK({density_output, resultValid}, 2'h2)
        rst = 1'b0;
        t_density();
        t_codes();
        t_faults();
        t_seek();
        test_done();
    end
endmodule : tb
